// ===== src/fcc_pkg.sv
// constants, codes and types shared by the flash command control block
// assumes an 8-bit register port, a 16-bit flash address space, one bus clock
//
// Summary of operation
// - key select low: key-range writes start commands
// - key select high: key-range writes load keys
// - protection register loads nonvolatile byte on first edge after reset release
// - protection register readable, writes ignored
// - boundary field bounds unprotected region; refuse protected
// - disable bit high protects nothing
// - writing one to buffer-empty launches; transfer refills
// - only burst program may wait in buffer
// - complete flag: buffer empty and idle; read-only
// - protected target ignored, sets violation; write-one clears
// - sequence, divider or stop faults set access error
// - access error clears on one, zero ignored
// - blank flag from blank check; clears on launch
// - codes 0x05, 0x20, 0x25 recognised
// - codes 0x40 page erase, 0x41 mass erase
// - any other code sets access error
// - blank pass or key match unsecures device
// - divider loaded flag set by first divider write
package fcc_pkg;
    // register port offsets
    localparam logic [2:0] FCC_OFS_CONFIG  = 3'h0;
    localparam logic [2:0] FCC_OFS_PROTECT = 3'h1;
    localparam logic [2:0] FCC_OFS_STATUS  = 3'h2;
    localparam logic [2:0] FCC_OFS_COMMAND = 3'h3;
    localparam logic [2:0] FCC_OFS_DIVIDER = 3'h4;
    // field positions
    localparam int FCC_CFG_KEYSEL_BIT  = 5;
    localparam int FCC_ST_CBEF_BIT     = 7;
    localparam int FCC_ST_CCF_BIT      = 6;
    localparam int FCC_ST_PVIOL_BIT    = 5;
    localparam int FCC_ST_ACCERR_BIT   = 4;
    localparam int FCC_ST_BLANK_BIT    = 2;
    localparam int FCC_DIV_LOADED_BIT  = 7;
    localparam int FCC_PROT_DIS_BIT    = 0;
    // command codes
    localparam logic [7:0] FCC_CMD_BLANK  = 8'h05;
    localparam logic [7:0] FCC_CMD_BYTE   = 8'h20;
    localparam logic [7:0] FCC_CMD_BURST  = 8'h25;
    localparam logic [7:0] FCC_CMD_PAGE   = 8'h40;
    localparam logic [7:0] FCC_CMD_MASS   = 8'h41;
    // backdoor key range and page size
    localparam logic [15:0] FCC_KEY_FIRST = 16'hFFB0;
    localparam logic [15:0] FCC_KEY_LAST  = 16'hFFB7;
    localparam logic [8:0]  FCC_PAGE_MASK = 9'h1FF;
    localparam logic [2:0]  FCC_KEY_LAST_IDX = 3'h7;
    // security codes and reset values
    localparam logic [1:0] FCC_SEC_UNSECURED = 2'h2;
    localparam logic [7:0] FCC_RST_PROT      = 8'hFF;
    localparam logic [1:0] FCC_RST_SEC       = 2'h0;
    localparam logic [7:0] FCC_RST_BYTE      = 8'h00;
    // command sequence position
    typedef enum logic [1:0] {
        FCC_SEQ_IDLE,
        FCC_SEQ_ADDR,
        FCC_SEQ_CMD
    } fcc_seq_t;
endpackage

// ===== src/fcc_key_check.sv
// backdoor key comparator: eight key bytes written in order against the stored key
// assumes byte 0 of the key sits in the top byte of the stored key input
`timescale 1ns/10ps
module fcc_key_check (
    input  wire logic        clk_sys_in,   // bus clock
    input  wire logic        reset_n_in,   // async reset, active low
    input  wire logic        key_wr_in,    // key byte write strobe
    input  wire logic [2:0]  key_idx_in,   // byte index in key range
    input  wire logic [7:0]  key_data_in,  // written key byte
    input  wire logic [63:0] nv_key_in,    // stored backdoor key
    output logic             key_ok_out    // one-cycle pulse on full match
);
    typedef struct packed {
        logic [2:0] expect_idx;  // next index in sequence
        logic       match;       // all bytes so far matched
        logic       ok;          // match pulse
    } fcc_key_st_t;

    fcc_key_st_t st_q;  // registered state
    fcc_key_st_t st_d;  // next state

    // picks one key byte, byte 0 most significant
    function automatic logic [7:0] key_byte(input logic [63:0] key, input logic [2:0] idx);
        key_byte = key[8'(63 - 8 * int'(idx)) -: 8];
    endfunction

    // compare each write; out-of-order writes poison the whole attempt
    always_comb begin
        logic good;
        good = 1'b0;
        st_d = st_q;
        st_d.ok = 1'b0;
        if (key_wr_in) begin
            good = (key_data_in == key_byte(nv_key_in, key_idx_in));
            if (key_idx_in == 3'h0) begin
                // byte 0 always restarts the attempt
                st_d.match = good;
                st_d.expect_idx = 3'h1;
            end else begin
                st_d.match = st_q.match & good & (key_idx_in == st_q.expect_idx);
                st_d.expect_idx = key_idx_in + 3'h1;
            end
            if (key_idx_in == fcc_pkg::FCC_KEY_LAST_IDX) begin
                st_d.ok = st_d.match;
                st_d.match = 1'b0;
                st_d.expect_idx = 3'h0;
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign key_ok_out = st_q.ok;
endmodule

// ===== src/fcc_top.sv
// flash command control: registers, command sequencing, protection and status
// assumes an array engine that takes a one-cycle start, raises done when finished,
// and reports blank result with done; register port inputs are synchronous
`timescale 1ns/10ps
module fcc_top (
    input  wire logic        clk_sys_in,      // bus clock
    input  wire logic        reset_n_in,      // async reset, active low
    // register port
    input  wire logic [2:0]  reg_addr_in,     // register offset
    input  wire logic [7:0]  reg_wdata_in,    // write data
    input  wire logic        reg_wr_in,       // write strobe
    input  wire logic        reg_rd_in,       // read strobe
    output logic      [7:0]  reg_rdata_out,   // read data, cycle after strobe
    // processor writes into the flash address space
    input  wire logic        arr_wr_in,       // array write strobe
    input  wire logic [15:0] arr_addr_in,     // array write address
    input  wire logic [7:0]  arr_data_in,     // array write data
    // nonvolatile values and system state
    input  wire logic [7:0]  nv_prot_in,      // nonvolatile protect byte
    input  wire logic [1:0]  nv_sec_in,       // nonvolatile security code
    input  wire logic [63:0] nv_key_in,       // nonvolatile backdoor key
    input  wire logic        stop_in,         // stop mode entry request
    // array engine
    input  wire logic        eng_done_in,     // command finished pulse
    input  wire logic        eng_blank_in,    // blank result, valid with done
    output logic             eng_start_out,   // start pulse
    output logic      [7:0]  eng_cmd_out,     // command code
    output logic      [15:0] eng_addr_out,    // target address
    output logic      [7:0]  eng_data_out,    // program data
    output logic             eng_abort_out,   // abort pulse on stop while engine busy
    output logic      [6:0]  div_out,         // clock divider setting
    output logic      [1:0]  sec_code_out     // security state code
);
    typedef struct packed {
        fcc_pkg::fcc_seq_t seq;       // sequence position
        logic [15:0]       addr;      // latched address, also the buffer
        logic [7:0]        data;      // latched data
        logic [7:0]        cmd;       // latched command
        logic              keysel;    // key write select
        logic [7:0]        prot;      // protection register
        logic              loaded;    // nonvolatile values captured
        logic [1:0]        sec;       // security state
        logic              cbef;      // buffer empty
        logic              pviol;     // protection violation
        logic              accerr;    // access error
        logic              blank;     // blank result
        logic              busy;      // engine running
        logic              run_blank; // engine runs a blank check
        logic              run_burst; // engine runs a burst program
        logic              div_ld;    // divider written since reset
        logic [6:0]        div;       // divider value
        logic              start;     // engine start pulse
        logic [7:0]        eng_cmd;   // engine command
        logic [15:0]       eng_addr;  // engine address
        logic [7:0]        eng_data;  // engine data
        logic              abort;     // engine abort pulse
        logic [7:0]        rdata;     // read data
    } fcc_st_t;

    fcc_st_t st_q;  // registered state
    fcc_st_t st_d;  // next state

    logic       key_wr;   // key byte write to comparator
    logic       key_ok;   // comparator match pulse
    logic       in_key;   // array write lands in key range
    logic       launch;   // buffer-empty written with one
    logic [7:0] status;   // composed status byte

    // true when address falls in the backdoor key bytes
    function automatic logic key_range(input logic [15:0] a);
        key_range = (a >= fcc_pkg::FCC_KEY_FIRST) && (a <= fcc_pkg::FCC_KEY_LAST);
    endfunction

    // true when a command may not touch its target
    function automatic logic is_protected(input logic [7:0] prot,
                                          input logic [7:0] cmd,
                                          input logic [15:0] a);
        logic       dis;
        logic [15:0] bound;
        dis   = prot[fcc_pkg::FCC_PROT_DIS_BIT];
        bound = {prot[7:1], fcc_pkg::FCC_PAGE_MASK};
        if (dis) begin
            is_protected = 1'b0;
        end else if (cmd == fcc_pkg::FCC_CMD_MASS) begin
            is_protected = 1'b1;
        end else if (cmd == fcc_pkg::FCC_CMD_BLANK) begin
            is_protected = 1'b0;
        end else begin
            is_protected = (a > bound);
        end
    endfunction

    // recognised command codes; everything else is illegal
    function automatic logic legal_cmd(input logic [7:0] c);
        case (c)
            fcc_pkg::FCC_CMD_BLANK,
            fcc_pkg::FCC_CMD_BYTE,
            fcc_pkg::FCC_CMD_BURST,
            fcc_pkg::FCC_CMD_PAGE,
            fcc_pkg::FCC_CMD_MASS:  legal_cmd = 1'b1;
            default:                legal_cmd = 1'b0;
        endcase
    endfunction

    // key bytes go to the comparator only with key select high
    assign in_key = key_range(arr_addr_in);
    assign key_wr = arr_wr_in & st_q.keysel & in_key;
    assign launch = reg_wr_in && (reg_addr_in == fcc_pkg::FCC_OFS_STATUS)
                    && reg_wdata_in[fcc_pkg::FCC_ST_CBEF_BIT];

    // status byte as software sees it; complete derived, never stored
    always_comb begin
        status = 8'h00;
        status[fcc_pkg::FCC_ST_CBEF_BIT]   = st_q.cbef;
        status[fcc_pkg::FCC_ST_CCF_BIT]    = st_q.cbef & ~st_q.busy;
        status[fcc_pkg::FCC_ST_PVIOL_BIT]  = st_q.pviol;
        status[fcc_pkg::FCC_ST_ACCERR_BIT] = st_q.accerr;
        status[fcc_pkg::FCC_ST_BLANK_BIT]  = st_q.blank;
    end

    fcc_key_check u_key_check (
        .clk_sys_in  (clk_sys_in),
        .reset_n_in  (reset_n_in),
        .key_wr_in   (key_wr),
        .key_idx_in  (arr_addr_in[2:0]),
        .key_data_in (arr_data_in),
        .nv_key_in   (nv_key_in),
        .key_ok_out  (key_ok)
    );

    // next-state logic; later assignments win, so error sets follow their clears
    always_comb begin
        logic fail;
        fail = 1'b0;
        st_d = st_q;
        st_d.start = 1'b0;
        st_d.abort = 1'b0;
        st_d.rdata = 8'h00;

        // capture nonvolatile values once, on the first edge after reset release
        if (!st_q.loaded) begin
            st_d.prot   = nv_prot_in;
            st_d.sec    = nv_sec_in;
            st_d.loaded = 1'b1;
        end

        // software clears by writing ones; zeros leave flags alone
        if (reg_wr_in && (reg_addr_in == fcc_pkg::FCC_OFS_STATUS)) begin
            if (reg_wdata_in[fcc_pkg::FCC_ST_PVIOL_BIT]) begin
                st_d.pviol = 1'b0;
            end
            if (reg_wdata_in[fcc_pkg::FCC_ST_ACCERR_BIT]) begin
                st_d.accerr = 1'b0;
            end
        end

        // plain register writes; protection register ignores writes
        if (reg_wr_in) begin
            case (reg_addr_in)
                fcc_pkg::FCC_OFS_CONFIG: begin
                    st_d.keysel = reg_wdata_in[fcc_pkg::FCC_CFG_KEYSEL_BIT];
                end
                fcc_pkg::FCC_OFS_DIVIDER: begin
                    st_d.div    = reg_wdata_in[6:0];
                    st_d.div_ld = 1'b1;
                end
                fcc_pkg::FCC_OFS_COMMAND: begin
                    // code accepted only right after the address write
                    if (st_q.seq != fcc_pkg::FCC_SEQ_ADDR) begin
                        fail = 1'b1;
                    end else if (!legal_cmd(reg_wdata_in)) begin
                        fail = 1'b1;
                    end else begin
                        st_d.cmd = reg_wdata_in;
                        st_d.seq = fcc_pkg::FCC_SEQ_CMD;
                    end
                end
                default: begin
                    // protection, status and unmapped: no stored effect here
                end
            endcase
        end

        // array write starts a sequence; key range counts unless key select is set
        if (arr_wr_in && !(st_q.keysel && in_key)) begin
            if (!st_q.div_ld) begin
                fail = 1'b1;
            end else if ((st_q.seq != fcc_pkg::FCC_SEQ_IDLE) || !st_q.cbef) begin
                fail = 1'b1;
            end else begin
                st_d.addr = arr_addr_in;
                st_d.data = arr_data_in;
                st_d.seq  = fcc_pkg::FCC_SEQ_ADDR;
            end
        end

        // launch: only a complete sequence, and only a burst behind a burst
        if (launch) begin
            if (st_q.seq != fcc_pkg::FCC_SEQ_CMD) begin
                fail = 1'b1;
            end else if (st_q.busy && !(st_q.run_burst
                         && (st_q.cmd == fcc_pkg::FCC_CMD_BURST))) begin
                fail = 1'b1;
            end else if (is_protected(st_q.prot, st_q.cmd, st_q.addr)) begin
                st_d.pviol = 1'b1;
                st_d.seq   = fcc_pkg::FCC_SEQ_IDLE;
            end else begin
                st_d.cbef  = 1'b0;
                st_d.blank = 1'b0;
                st_d.seq   = fcc_pkg::FCC_SEQ_IDLE;
            end
        end

        // engine finished: blank result and possible unlock
        if (eng_done_in && st_q.busy) begin
            st_d.busy = 1'b0;
            if (st_q.run_blank) begin
                st_d.blank = eng_blank_in;
                if (eng_blank_in) begin
                    st_d.sec = fcc_pkg::FCC_SEC_UNSECURED;
                end
            end
        end

        // buffered command moves into the array once the engine is free
        if (!st_q.cbef && !st_q.busy) begin
            st_d.start     = 1'b1;
            st_d.eng_cmd   = st_q.cmd;
            st_d.eng_addr  = st_q.addr;
            st_d.eng_data  = st_q.data;
            st_d.busy      = 1'b1;
            st_d.cbef      = 1'b1;
            st_d.run_blank = (st_q.cmd == fcc_pkg::FCC_CMD_BLANK);
            st_d.run_burst = (st_q.cmd == fcc_pkg::FCC_CMD_BURST);
        end

        // correct key entry unlocks until next reset
        if (key_ok) begin
            st_d.sec = fcc_pkg::FCC_SEC_UNSECURED;
        end

        // any sequence fault drops the partial command
        if (fail) begin
            st_d.accerr = 1'b1;
            st_d.seq    = fcc_pkg::FCC_SEQ_IDLE;
        end

        // stop during activity kills everything; takes precedence over issue
        if (stop_in && (st_q.busy || !st_q.cbef || (st_q.seq != fcc_pkg::FCC_SEQ_IDLE))) begin
            st_d.accerr    = 1'b1;
            st_d.seq       = fcc_pkg::FCC_SEQ_IDLE;
            st_d.busy      = 1'b0;
            st_d.cbef      = 1'b1;
            st_d.start     = 1'b0;
            st_d.abort     = st_q.busy | st_d.start;
            st_d.run_blank = 1'b0;
            st_d.run_burst = 1'b0;
        end

        // read mux; data shows only in the cycle after the strobe
        if (reg_rd_in) begin
            case (reg_addr_in)
                fcc_pkg::FCC_OFS_CONFIG: begin
                    st_d.rdata = 8'h00;
                    st_d.rdata[fcc_pkg::FCC_CFG_KEYSEL_BIT] = st_q.keysel;
                end
                fcc_pkg::FCC_OFS_PROTECT: st_d.rdata = st_q.prot;
                fcc_pkg::FCC_OFS_STATUS:  st_d.rdata = status;
                fcc_pkg::FCC_OFS_COMMAND: st_d.rdata = st_q.cmd;
                fcc_pkg::FCC_OFS_DIVIDER: st_d.rdata = {st_q.div_ld, st_q.div};
                default:                  st_d.rdata = 8'h00;    // unmapped reads zero
            endcase
        end
    end

    // state register; reset leaves buffer empty and idle, so complete reads one
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_q       <= '0;
            st_q.seq   <= fcc_pkg::FCC_SEQ_IDLE;
            st_q.prot  <= fcc_pkg::FCC_RST_PROT;
            st_q.sec   <= fcc_pkg::FCC_RST_SEC;
            st_q.cmd   <= fcc_pkg::FCC_RST_BYTE;
            st_q.cbef  <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state register
    assign reg_rdata_out = st_q.rdata;
    assign eng_start_out = st_q.start;
    assign eng_cmd_out   = st_q.eng_cmd;
    assign eng_addr_out  = st_q.eng_addr;
    assign eng_data_out  = st_q.eng_data;
    assign eng_abort_out = st_q.abort;
    assign div_out       = st_q.div;
    assign sec_code_out  = st_q.sec;
endmodule

// ===== tb/fcc_eng_model.sv
// array engine model: takes a start pulse, finishes after a fixed delay
// assumes start and abort are one-cycle pulses from the command control
`timescale 1ns/10ps
module fcc_eng_model (
    input  wire logic clk_sys_in,   // bus clock
    input  wire logic reset_n_in,   // async reset, active low
    input  wire logic start_in,     // start pulse
    input  wire logic abort_in,     // abort pulse
    input  wire logic blank_val_in, // array content is all erased
    output logic      done_out,     // finished pulse
    output logic      blank_out     // blank result, valid with done
);
    logic [3:0] cnt_q; // cycles left in the running command
    // countdown; done never shares a cycle with start
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt_q <= 4'h0;
        end else if (abort_in) begin
            cnt_q <= 4'h0; // aborted work never reports done
        end else if (start_in) begin
            cnt_q <= 4'h6;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end
    assign done_out  = (cnt_q == 4'h1);
    // outside done the line carries garbage, not the result
    assign blank_out = done_out ? blank_val_in : ~blank_val_in;
endmodule

// ===== tb/fcc_top_asserts.sv
// checker for the flash command control, sees top ports only
// assumes nv_prot_in only changes while reset is held
`timescale 1ns/10ps
module fcc_top_asserts (
    input wire logic        clk_sys_in,
    input wire logic        reset_n_in,
    input wire logic [2:0]  reg_addr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic [7:0]  nv_prot_in,
    input wire logic        stop_in,
    input wire logic        eng_done_in,
    input wire logic        eng_blank_in,
    input wire logic        eng_start_out,
    input wire logic [7:0]  eng_cmd_out,
    input wire logic [15:0] eng_addr_out,
    input wire logic        eng_abort_out,
    input wire logic [6:0]  div_out,
    input wire logic [1:0]  sec_code_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    logic dl_q; // divider written since reset
    // mirror of the divider loaded flag
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dl_q <= 1'b0;
        end else if (reg_wr_in && reg_addr_in == 3'h4) begin
            dl_q <= 1'b1;
        end
    end
    start_pulse_a: assert property (eng_start_out |=> !eng_start_out)
        else $error("start longer than one cycle");
    rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("read data outside read slot");
    abort_cause_a: assert property (eng_abort_out |-> $past(stop_in))
        else $error("abort without stop");
    legal_code_a: assert property (eng_start_out |-> eng_cmd_out inside
        {8'h05, 8'h20, 8'h25, 8'h40, 8'h41}) else $error("illegal code started");
    cmd_hold_a: assert property (!eng_start_out |-> $stable(eng_addr_out))
        else $error("engine address moved");
    div_load_a: assert property (reg_wr_in && reg_addr_in == 3'h4
        |=> div_out == $past(reg_wdata_in[6:0])) else $error("divider not taken");
    div_gate_a: assert property (eng_start_out |-> dl_q)
        else $error("start before divider write");
    blank_sec_a: assert property (eng_done_in && eng_blank_in && eng_cmd_out == 8'h05
        |=> sec_code_out == 2'h2) else $error("blank pass left secured");
    prot_refuse_a: assert property (eng_start_out && !nv_prot_in[0]
        && eng_cmd_out != 8'h05 |-> eng_cmd_out != 8'h41
        && eng_addr_out <= {nv_prot_in[7:1], 9'h1FF}) else $error("protected start");
endmodule
bind fcc_top fcc_top_asserts fcc_top_asserts_inst (.*);

// ===== tb/tb_top.sv
// self-checking bench for the flash command control with engine model
// assumes the register port and nonvolatile inputs are driven here
`timescale 1ns/10ps
module tb_top;
    logic clk_sys_in = 0, reset_n_in = 0, reg_wr_in = 0, reg_rd_in = 0;
    logic arr_wr_in = 0, stop_in = 0, blank_val = 1, eng_done_in, eng_blank_in;
    logic [2:0] reg_addr_in = 0;
    logic [7:0] reg_wdata_in = 0, arr_data_in = 0, nv_prot_in = 8'hFF;
    logic [15:0] arr_addr_in = 0;
    logic [63:0] nv_key_in = 64'h0123_4567_89AB_CDEF; // test key
    logic [7:0] reg_rdata_out, eng_cmd_out, eng_data_out;
    logic [15:0] eng_addr_out;
    logic eng_start_out, eng_abort_out;
    logic [6:0] div_out;
    logic [1:0] sec_code_out;
    int err_total = 0, checks_done = 0;
    logic [7:0] codes [5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
    fcc_top fcc_top_inst (.clk_sys_in, .reset_n_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .arr_wr_in, .arr_addr_in, .arr_data_in,
        .nv_prot_in, .nv_sec_in(2'h0), .nv_key_in, .stop_in, .eng_done_in,
        .eng_blank_in, .eng_start_out, .eng_cmd_out, .eng_addr_out, .eng_data_out,
        .eng_abort_out, .div_out, .sec_code_out);
    fcc_eng_model fcc_eng_model_inst (.clk_sys_in, .reset_n_in, .start_in(eng_start_out),
        .abort_in(eng_abort_out), .blank_val_in(blank_val), .done_out(eng_done_in),
        .blank_out(eng_blank_in));
    initial begin
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    task automatic report_and_stop;
        if (err_total == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tmo;
        err_total++; // a hung wait counts as a mismatch
        report_and_stop;
    endtask
    // register write, one strobe cycle
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        reg_wr_in <= 1; reg_addr_in <= a; reg_wdata_in <= d;
        @(posedge clk_sys_in);
        reg_wr_in <= 0;
    endtask
    // register read, data judged in the slot after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk_sys_in);
        reg_rd_in <= 1; reg_addr_in <= a;
        @(posedge clk_sys_in);
        reg_rd_in <= 0;
        #1 chk(reg_rdata_out, e);
    endtask
    task automatic arr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        arr_wr_in <= 1; arr_addr_in <= a; arr_data_in <= d;
        @(posedge clk_sys_in);
        arr_wr_in <= 0;
    endtask
    task automatic rst(input logic [7:0] p);
        reset_n_in <= 0; nv_prot_in <= p;
        repeat (5) @(posedge clk_sys_in);
        reset_n_in <= 1;
        @(posedge clk_sys_in);
    endtask
    // wait for a one-cycle output pulse, bounded
    task automatic wait_pulse(ref logic s);
        for (int i = 0; i < 20; i++) begin
            @(posedge clk_sys_in);
            #1;
            if (s === 1'b1) return;
        end
        tmo;
    endtask
    // full sequence; go says whether the engine must start
    task automatic do_cmd(input logic [15:0] a, input logic [7:0] c,
                          input logic [7:0] es, input bit go);
        arr(a, 8'h5A); wr(3'h3, c); wr(3'h2, 8'h80);
        if (go) begin
            wait_pulse(eng_start_out);
            chk(eng_cmd_out, c);
            chk(eng_addr_out, a);
            chk(eng_data_out, 8'h5A);
            wait_pulse(eng_done_in);
            repeat (2) @(posedge clk_sys_in);
        end
        rd(3'h2, es);
    endtask
    task automatic s_reset;
        rd(3'h2, 8'hC0);
        rd(3'h1, 8'hFF);
        wr(3'h1, 8'h00); rd(3'h1, 8'hFF);
        rd(3'h4, 8'h00);
        rd(3'h6, 8'h00);
        do_cmd(16'h1000, 8'h20, 8'hD0, 0);
        wr(3'h2, 8'h00); rd(3'h2, 8'hD0);
        wr(3'h2, 8'h10); rd(3'h2, 8'hC0);
        wr(3'h4, 8'h13); rd(3'h4, 8'h93);
    endtask
    // every code once; key range with select low starts commands
    task automatic s_codes;
        foreach (codes[i]) begin
            // no blank check follows the mass erase; software may skip it
            do_cmd(16'hFFB0, codes[i], codes[i] == 8'h05 ? 8'hC4 : 8'hC0, 1);
        end
        chk(sec_code_out, 2'h2);
        do_cmd(16'h1000, 8'h33, 8'hD0, 0);
        wr(3'h2, 8'h10);
        rd(3'h3, 8'h41);
    endtask
    task automatic s_prot;
        rd(3'h1, 8'h7E); wr(3'h4, 8'h01);
        do_cmd(16'h8000, 8'h20, 8'hE0, 0);
        do_cmd(16'h0000, 8'h41, 8'hE0, 0);
        wr(3'h2, 8'h20); rd(3'h2, 8'hC0);
        do_cmd(16'h7FFF, 8'h20, 8'hC0, 1);
    endtask
    task automatic s_stop;
        arr(16'h0200, 8'h00); wr(3'h3, 8'h40); wr(3'h2, 8'h80);
        wait_pulse(eng_start_out);
        // stop raised on a clock edge while the engine is busy
        @(posedge clk_sys_in);
        stop_in <= 1;
        @(posedge clk_sys_in);
        stop_in <= 0;
        // abort stands for one cycle only, so look right after its edge
        #1 chk(eng_abort_out, 16'h0001);
        rd(3'h2, 8'hD0);
        wr(3'h2, 8'h10);
    endtask
    // key bytes in order while key select is high
    task automatic s_key;
        chk(sec_code_out, 2'h0);
        wr(3'h0, 8'h20); rd(3'h0, 8'h20);
        for (int i = 0; i < 8; i++) begin
            arr(16'hFFB0 + 16'(i), nv_key_in[63 - 8 * i -: 8]);
        end
        repeat (3) @(posedge clk_sys_in);
        chk(sec_code_out, 2'h2);
        rd(3'h2, 8'hC0);
    endtask
    initial begin
        rst(8'hFF);
        s_reset;
        s_codes;
        rst(8'h7E);
        s_prot;
        s_stop;
        s_key;
        report_and_stop;
    end
endmodule
